// ==== logic/accel_err_cfg.svh ====
// Timing, field positions and reply codes of the accelerometer reply path.
`ifndef ACCEL_ERR_CFG_SVH
`define ACCEL_ERR_CFG_SVH
`define MCLK_MHZ 200
`define INIT1_TIME_US 800
`define INIT2_TIME_US 3000
`define INIT2_HPF_EXTRA_US 200000
`define FRAME_EDGES 5'h10
`define EDGE_SAT 5'h11
`define CMD_BIT_OP_HI 15
`define CMD_BIT_OP_LO 14
`define CMD_BIT_ACC 13
`define RSP_BIT_PAR 12
`define ST_NONE 2'h0
`define ST_ACCEL 2'h1
`define ST_SELFTEST 2'h2
`define ST_ERROR 2'h3
`define EB_CRIT_DATA 9
`define EB_DEV_RESET 7
`define EB_DEV_INIT 6
`define EB_HW 5
`define EB_NO_DATA 4
`define EB_AXIS 3
`define EB_CLOCK 2
`define EB_REQUEST 1
`define EB_SPI 0
`define LIN_MAX 12'sh1FC
`define LIN_MIN 12'shE03
`define CODE_OVERRANGE 10'h1FD
`define CODE_OVERFLOW 10'h1FE
`define CODE_UNDERRANGE 10'h202
`define CODE_UNDERFLOW 10'h201
`define CODE_RSV_POS 10'h1FF
`define CODE_RSV_NEG 10'h200
`define OFFSET_LIMIT 10'h034
`define RESET_FRAME 16'h1C90
`endif

// ==== logic/accel_err_pkg.sv ====
// Types shared by the accelerometer reply path.
package accel_err_pkg;
  typedef enum logic [1:0] {INIT_ONE, INIT_TWO, RUNNING} init_phase_t;
  typedef enum logic [2:0] {
    CLS_NONE, CLS_EXTERNAL, CLS_TRANSIENT, CLS_RESET, CLS_CRITICAL
  } err_class_t;
endpackage

// ==== logic/accel_err_status.sv ====
// Serial reply path: frame checks, error classes and data encoding.
`include "accel_err_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module accel_err_status #(
  parameter int INIT1_CYCLES = `INIT1_TIME_US * `MCLK_MHZ,
  parameter int INIT2_CYCLES = `INIT2_TIME_US * `MCLK_MHZ,
  parameter int INIT2_HPF_CYCLES =
    (`INIT2_TIME_US + `INIT2_HPF_EXTRA_US) * `MCLK_MHZ,
  parameter logic [1:0] AXIS_SUPPORTED = 2'h3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  output logic spi_dout,
  output logic spi_dout_oe_n,
  input wire logic undervoltage,
  input wire logic reset_request,
  input wire logic clear_error,
  input wire logic hpf_select,
  input wire logic offset_monitor_enable,
  input wire logic signed [9:0] offset_mon,
  input wire logic temp_over,
  input wire logic parity_fault,
  input wire logic osc_fault,
  input wire logic self_test_active,
  input wire logic signed [11:0] accel_x,
  input wire logic signed [11:0] accel_y,
  input wire logic accel_x_clip,
  input wire logic accel_y_clip,
  output logic [15:0] cmd_word,
  output logic cmd_valid,
  output logic reset_occurred_flag,
  output logic init_busy,
  output logic temp_fault_flag,
  output logic offset_fault_flag,
  output logic data_error_flag,
  output accel_err_pkg::err_class_t reported_class
);

  function automatic logic [9:0] encode(input logic signed [11:0] raw,
                                        input logic clip);
    logic [9:0] code;
    code = raw[9:0];
    if (clip) begin
      code = raw[11] ? `CODE_UNDERFLOW : `CODE_OVERFLOW;
    end else if (raw > `LIN_MAX) begin
      code = `CODE_OVERRANGE;
    end else if (raw < `LIN_MIN) begin
      code = `CODE_UNDERRANGE;
    end
    return code;
  endfunction

  function automatic logic [15:0] mk_frame(input logic axis,
                                           input logic [1:0] st,
                                           input logic [9:0] data);
    logic [15:0] w;
    w = {2'h0, axis, 1'h0, st, data};
    w[`RSP_BIT_PAR] = ~^w;
    return w;
  endfunction

  // Link side: runs only on the master's clock inside a frame.
  logic [15:0] rx_sh_q;
  logic [4:0] edge_cnt_q;
  logic link_clr_q;

  always_ff @(posedge spi_sclk or posedge link_clr_q) begin
    if (link_clr_q) begin
      rx_sh_q <= 16'h0000;
      edge_cnt_q <= 5'h00;
    end else if (!spi_cs_n) begin
      rx_sh_q <= {rx_sh_q[14:0], spi_din};
      if (edge_cnt_q != `EDGE_SAT) begin
        edge_cnt_q <= edge_cnt_q + 5'h01;
      end
    end
  end

  // Pin synchronisers.
  logic cs_s1_q, cs_s2_q, sclk_s1_q, sclk_s2_q, uv_s1_q, uv_s2_q;
  logic cs_prev_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'h1;
      cs_s2_q <= 1'h1;
      sclk_s1_q <= 1'h0;
      sclk_s2_q <= 1'h0;
      uv_s1_q <= 1'h0;
      uv_s2_q <= 1'h0;
      cs_prev_q <= 1'h1;
    end else if (clk_en) begin
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      sclk_s1_q <= spi_sclk;
      sclk_s2_q <= sclk_s1_q;
      uv_s1_q <= undervoltage;
      uv_s2_q <= uv_s1_q;
      cs_prev_q <= cs_s2_q;
    end
  end

  logic frame_start, frame_end;
  assign frame_start = cs_prev_q && !cs_s2_q;
  assign frame_end = !cs_prev_q && cs_s2_q;

  // Controller reset request and undervoltage re-run the whole start-up.
  logic soft_rst_q, int_rst;
  assign int_rst = soft_rst_q || uv_s2_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soft_rst_q <= 1'h0;
    end else if (clk_en) begin
      soft_rst_q <= reset_request;
    end
  end

  // Initialisation sequencing.
  accel_err_pkg::init_phase_t phase_q;
  logic [25:0] init_cnt_q;
  logic [25:0] init2_last;
  assign init2_last = hpf_select ? 26'(INIT2_HPF_CYCLES - 1)
                                 : 26'(INIT2_CYCLES - 1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q <= accel_err_pkg::INIT_ONE;
      init_cnt_q <= 26'h0000000;
    end else if (clk_en) begin
      if (int_rst) begin
        phase_q <= accel_err_pkg::INIT_ONE;
        init_cnt_q <= 26'h0000000;
      end else begin
        unique case (phase_q)
          accel_err_pkg::INIT_ONE: begin
            if (init_cnt_q == 26'(INIT1_CYCLES - 1)) begin
              phase_q <= accel_err_pkg::INIT_TWO;
              init_cnt_q <= 26'h0000000;
            end else begin
              init_cnt_q <= init_cnt_q + 26'h0000001;
            end
          end
          accel_err_pkg::INIT_TWO: begin
            if (init_cnt_q >= init2_last) begin
              phase_q <= accel_err_pkg::RUNNING;
            end else begin
              init_cnt_q <= init_cnt_q + 26'h0000001;
            end
          end
          accel_err_pkg::RUNNING: begin
            init_cnt_q <= init_cnt_q;
          end
        endcase
      end
    end
  end
  assign init_busy = phase_q != accel_err_pkg::RUNNING;

  // Frame capture. The link counters are read only while select is high,
  // so the master's clock is still and the words are stable.
  logic start_fault_q;
  logic cap;
  assign cap = frame_end && !int_rst &&
               phase_q != accel_err_pkg::INIT_ONE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_clr_q <= 1'h1;
      start_fault_q <= 1'h0;
    end else if (clk_en) begin
      if (frame_start) begin
        link_clr_q <= 1'h0;
        start_fault_q <= sclk_s2_q;
      end else if (frame_end) begin
        link_clr_q <= 1'h1;
      end
    end
  end

  // Sticky flags; a new event in the clearing cycle wins.
  logic offset_hit, ce_ok;
  assign offset_hit = offset_monitor_enable &&
    ((offset_mon[9] ? 10'(-offset_mon) : offset_mon) >= `OFFSET_LIMIT);
  assign ce_ok = clear_error && phase_q == accel_err_pkg::RUNNING;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reset_occurred_flag <= 1'h1;
    end else if (clk_en) begin
      if (int_rst) begin
        reset_occurred_flag <= 1'h1;
      end else if (ce_ok) begin
        reset_occurred_flag <= 1'h0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      temp_fault_flag <= 1'h0;
      offset_fault_flag <= 1'h0;
    end else if (clk_en) begin
      if (int_rst) begin
        temp_fault_flag <= 1'h0;
        offset_fault_flag <= 1'h0;
      end else begin
        temp_fault_flag <= temp_over ||
          (temp_fault_flag && !clear_error);
        offset_fault_flag <= offset_hit ||
          (offset_fault_flag && !clear_error);
      end
    end
  end

  // A flipped register bit can only be recovered by a reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_error_flag <= 1'h0;
    end else if (clk_en) begin
      if (int_rst) begin
        data_error_flag <= 1'h0;
      end else if (parity_fault) begin
        data_error_flag <= 1'h1;
      end
    end
  end

  // Reply selection; each reply goes out in the following frame.
  logic spi_err, acc_req, axis, axis_bad, nd_pending_q;
  logic [15:0] frame_d, tx_q;
  logic [9:0] crit_bits;
  accel_err_pkg::err_class_t class_d;

  assign spi_err = start_fault_q || sclk_s2_q ||
                   edge_cnt_q != `FRAME_EDGES;
  assign acc_req = rx_sh_q[`CMD_BIT_ACC];
  assign axis = rx_sh_q[`CMD_BIT_OP_LO];
  assign axis_bad = !AXIS_SUPPORTED[axis];
  assign crit_bits = data_error_flag ? 10'h200 : 10'h000;

  always_comb begin
    frame_d = mk_frame(1'h0, `ST_NONE, 10'h000);
    class_d = accel_err_pkg::CLS_NONE;
    if (spi_err) begin
      frame_d = mk_frame(1'h0, `ST_ERROR, crit_bits | 10'h001);
      class_d = data_error_flag ? accel_err_pkg::CLS_CRITICAL
                                : accel_err_pkg::CLS_EXTERNAL;
    end else if (acc_req) begin
      // Priority: critical, reset/init, transient, external.
      if (data_error_flag) begin
        frame_d = mk_frame(axis, `ST_ERROR, crit_bits);
        class_d = accel_err_pkg::CLS_CRITICAL;
      end else if (phase_q == accel_err_pkg::INIT_TWO) begin
        frame_d = mk_frame(axis, `ST_ERROR, 10'h050);
        class_d = accel_err_pkg::CLS_RESET;
      end else if (nd_pending_q) begin
        frame_d = mk_frame(axis, `ST_ERROR, 10'h010);
        class_d = accel_err_pkg::CLS_RESET;
      end else if (temp_fault_flag || offset_fault_flag) begin
        frame_d = mk_frame(axis, `ST_ERROR, 10'h020);
        class_d = accel_err_pkg::CLS_TRANSIENT;
      end else if (axis_bad) begin
        frame_d = mk_frame(axis, `ST_ERROR, 10'h008);
        class_d = accel_err_pkg::CLS_EXTERNAL;
      end else begin
        frame_d = mk_frame(axis,
          self_test_active ? `ST_SELFTEST : `ST_ACCEL,
          axis ? encode(accel_y, accel_y_clip)
               : encode(accel_x, accel_x_clip));
      end
    end else if (rx_sh_q[15:14] == 2'h0) begin
      frame_d = mk_frame(1'h0, `ST_ERROR, 10'h002);
      class_d = accel_err_pkg::CLS_EXTERNAL;
    end
  end

  // External causes are not stored, so each shows in one reply only.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_q <= `RESET_FRAME;
      reported_class <= accel_err_pkg::CLS_RESET;
      cmd_word <= 16'h0000;
      cmd_valid <= 1'h0;
    end else if (clk_en) begin
      cmd_valid <= 1'h0;
      if (int_rst) begin
        tx_q <= `RESET_FRAME;
        reported_class <= accel_err_pkg::CLS_RESET;
      end else if (cap) begin
        tx_q <= frame_d;
        reported_class <= class_d;
        cmd_word <= rx_sh_q;
        cmd_valid <= !spi_err && !acc_req && rx_sh_q[15:14] != 2'h0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nd_pending_q <= 1'h1;
    end else if (clk_en) begin
      if (int_rst) begin
        nd_pending_q <= 1'h1;
      end else if (cap && !spi_err && acc_req && !data_error_flag &&
                   phase_q == accel_err_pkg::RUNNING) begin
        nd_pending_q <= 1'h0;
      end
    end
  end

  // Data out changes right after each rising edge; the master samples
  // on the next rising edge, so a whole link period of setup remains.
  always_comb begin
    spi_dout = 1'h0;
    if (osc_fault) begin
      spi_dout = 1'h1;
    end else if (edge_cnt_q < `FRAME_EDGES) begin
      spi_dout = tx_q[4'hF - edge_cnt_q[3:0]];
    end
  end
  assign spi_dout_oe_n = spi_cs_n ||
                         phase_q == accel_err_pkg::INIT_ONE;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || !clk_en);

  sequence s_init_done;
    phase_q == accel_err_pkg::INIT_TWO ##1
    phase_q == accel_err_pkg::RUNNING;
  endsequence

  sequence s_acc_capture;
    cap && acc_req && !spi_err;
  endsequence

  a_phase_one_quiet:
    assert property (phase_q == accel_err_pkg::INIT_ONE |-> spi_dout_oe_n)
    else $error("Reply driven during phase one.");

  a_osc_dout_high:
    assert property (osc_fault |-> spi_dout)
    else $error("Data out not high under oscillator fault.");

  a_spi_err_frame:
    assert property (cap && spi_err && !int_rst |=>
      tx_q[11:10] == `ST_ERROR && tx_q[`EB_SPI] && tx_q[13] == 1'h0)
    else $error("Framing error frame wrong.");

  a_edge_count:
    assert property (cap && edge_cnt_q != `FRAME_EDGES && !data_error_flag
      |=> reported_class == accel_err_pkg::CLS_EXTERNAL)
    else $error("Edge count fault not external class.");

  a_crit_always:
    assert property (cap && data_error_flag && (acc_req || spi_err)
      |=> tx_q[`EB_CRIT_DATA] && tx_q[11:10] == `ST_ERROR)
    else $error("Critical error not reported.");

  a_init_nodata:
    assert property (s_acc_capture and (!data_error_flag &&
      phase_q == accel_err_pkg::INIT_TWO) |=>
      tx_q[`EB_NO_DATA] && tx_q[`EB_DEV_INIT])
    else $error("Init request not answered with no-data.");

  a_first_nodata:
    assert property (s_init_done |-> nd_pending_q)
    else $error("No-data not pending after init.");

  a_reset_flag_hold:
    assert property (reset_occurred_flag && init_busy |=>
      reset_occurred_flag)
    else $error("Reset flag cleared before init completed.");

  a_transient_set:
    assert property (temp_over && clear_error && !int_rst |=>
      temp_fault_flag ##1 (temp_fault_flag || !$past(temp_over)))
    else $error("Transient flag lost while condition persists.");

  a_no_reserved:
    assert property (s_acc_capture |=> tx_q[11:10] != `ST_ERROR |->
      tx_q[9:0] != `CODE_RSV_POS && tx_q[9:0] != `CODE_RSV_NEG)
    else $error("Reserved data code sent.");

  a_status_nonzero:
    assert property (s_acc_capture and !int_rst |=> tx_q[11:10] != `ST_NONE)
    else $error("Acceleration reply with status zero.");

endmodule
`default_nettype wire

// ==== verification/spi_host_model.sv ====
// Host-side serial master model that runs whole frames on the link clock.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_din,
  input wire logic spi_dout,
  input wire logic spi_dout_oe_n
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_din = 1'b0;
  end

  // The link clock stands low between frames; a half period is 24 ns.
  // A caller may ask for a wrong edge count or a high clock at the select
  // edges, so the device's fault detection can be exercised on purpose.
  task automatic xfer(input logic [15:0] cmd, input int edges,
                      input bit hi, output logic [15:0] rsp,
                      output bit drv);
    int k;
    rsp = 16'h0000;
    drv = 1'b0;
    if (hi) begin
      spi_sclk = 1'b1;
      #24;
    end
    spi_cs_n = 1'b0;
    #24;
    spi_sclk = 1'b0;
    for (k = 0; k < edges; k++) begin
      spi_din = (k < 16) ? cmd[15 - k] : 1'b0;
      #24;
      if (k < 16) rsp[15 - k] = spi_dout;
      if (spi_dout_oe_n === 1'b0) drv = 1'b1;
      spi_sclk = 1'b1;
      #24;
      spi_sclk = 1'b0;
    end
    if (hi) spi_sclk = 1'b1;
    #24;
    spi_cs_n = 1'b1;
    if (hi) #24;
    spi_sclk = 1'b0;
    // A released data line must not keep showing the last bit.
    spi_din = ~spi_din;
    #100;
  endtask
endmodule
`default_nettype wire

// ==== verification/accel_spi_error_status_test.sv ====
// Self-checking bench for the serial reply path of the accelerometer.
`include "accel_err_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module accel_spi_error_status_test;
  localparam int I1 = 400;
  localparam int I2 = 2000;
  localparam logic signed [11:0] CORNER [4] =
    '{12'sh1FC, 12'sh1FD, 12'shE03, 12'shE02};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe_n;
  logic undervoltage = 1'b0;
  logic reset_request = 1'b0;
  logic clear_error = 1'b0;
  logic offset_monitor_enable = 1'b0;
  logic signed [9:0] offset_mon = 10'sh000;
  logic temp_over = 1'b0;
  logic parity_fault = 1'b0;
  logic osc_fault = 1'b0;
  logic self_test_active = 1'b0;
  logic signed [11:0] accel_x = 12'sh000;
  logic signed [11:0] accel_y = 12'sh000;
  logic accel_x_clip = 1'b0;
  logic accel_y_clip = 1'b0;
  logic [15:0] cmd_word;
  logic cmd_valid, reset_occurred_flag, init_busy;
  logic temp_fault_flag, offset_fault_flag, data_error_flag;
  logic [15:0] rsp, pend, got_cmd;
  accel_err_pkg::err_class_t cls;
  bit drv, pv;
  int mismatches = 0;
  int total_checks = 0;

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (cmd_valid === 1'b1) got_cmd <= cmd_word;

  spi_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n));

  accel_err_status #(.INIT1_CYCLES(I1), .INIT2_CYCLES(I2),
    .INIT2_HPF_CYCLES(2 * I2), .AXIS_SUPPORTED(2'h3)) dut (
    .mclk(mclk), .rst(rst), .clk_en(1'b1), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
    .spi_dout_oe_n(spi_dout_oe_n), .undervoltage(undervoltage),
    .reset_request(reset_request), .clear_error(clear_error),
    .hpf_select(1'b0), .offset_monitor_enable(offset_monitor_enable),
    .offset_mon(offset_mon), .temp_over(temp_over),
    .parity_fault(parity_fault), .osc_fault(osc_fault),
    .self_test_active(self_test_active), .accel_x(accel_x),
    .accel_y(accel_y), .accel_x_clip(accel_x_clip),
    .accel_y_clip(accel_y_clip), .cmd_word(cmd_word),
    .cmd_valid(cmd_valid), .reset_occurred_flag(reset_occurred_flag),
    .init_busy(init_busy), .temp_fault_flag(temp_fault_flag),
    .offset_fault_flag(offset_fault_flag),
    .data_error_flag(data_error_flag), .reported_class(cls));

  function automatic logic [15:0] mk(input logic ax, input logic [1:0] st,
                                     input logic [9:0] d);
    logic [15:0] w;
    w = {2'b00, ax, 1'b0, st, d};
    w[12] = ~^w;
    return w;
  endfunction

  function automatic logic [9:0] enc(input logic signed [11:0] v,
                                     input logic clip);
    if (clip) return (v < 0) ? `CODE_UNDERFLOW : `CODE_OVERFLOW;
    if (v > `LIN_MAX) return `CODE_OVERRANGE;
    if (v < `LIN_MIN) return `CODE_UNDERRANGE;
    return v[9:0];
  endfunction

  function automatic logic [15:0] acmd(input logic ax);
    return {1'b0, ax, 1'b1, 13'h0000};
  endfunction

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A reply only shows in the following frame, so each frame checks the
  // expectation left behind by the one before it.
  task automatic xf(input logic [15:0] cmd, input int edges, input bit hi,
                    input logic [15:0] exp, input bit ev);
    host.xfer(cmd, edges, hi, rsp, drv);
    if (pv) check("reply", rsp, pend);
    pend = exp;
    pv = ev;
  endtask

  task automatic pulse(input int which);
    @(posedge mclk);
    case (which)
      0: clear_error <= 1'b1;
      1: reset_request <= 1'b1;
      default: parity_fault <= 1'b1;
    endcase
    @(posedge mclk);
    clear_error <= 1'b0;
    reset_request <= 1'b0;
    parity_fault <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic wait_init();
    int n;
    for (n = 0; n < 3 * I2 && init_busy !== 1'b0; n++) @(posedge mclk);
    check("init done", {15'h0000, init_busy}, 16'h0000);
  endtask

  initial begin
    #300us;
    mismatches++;
    end_sim();
  end

  initial begin
    int i;
    logic ax;
    logic c;
    logic signed [11:0] v;
    void'($urandom(59668));
    pv = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    xf(acmd(1'b0), 16, 1'b0, 16'h0000, 1'b0);
    check("phase one drive", {15'h0000, drv}, 16'h0000);
    repeat (I1) @(posedge mclk);
    xf(acmd(1'b1), 16, 1'b0, 16'h0000, 1'b0);
    check("first reply", rsp, `RESET_FRAME);
    xf(acmd(1'b0), 16, 1'b0, mk(1'b0, `ST_ERROR, 10'h050), 1'b1);
    xf(acmd(1'b1), 16, 1'b0, mk(1'b1, `ST_ERROR, 10'h050), 1'b1);
    xf(16'h4A5C, 16, 1'b0, 16'h0000, 1'b0);
    check("register op", got_cmd, 16'h4A5C);
    pulse(0);
    check("reset flag", {15'h0000, reset_occurred_flag}, 16'h0001);
    wait_init();
    pulse(0);
    check("reset flag", {15'h0000, reset_occurred_flag}, 16'h0000);
    xf(acmd(1'b0), 16, 1'b0, mk(1'b0, `ST_ERROR, 10'h010), 1'b1);
    for (i = 0; i < 12; i++) begin
      ax = 1'($urandom);
      v = (i < 4) ? CORNER[i] : 12'($urandom);
      c = ($urandom % 6) == 0;
      @(posedge mclk);
      accel_x <= ax ? ~v : v;
      accel_y <= ax ? v : ~v;
      accel_x_clip <= c & ~ax;
      accel_y_clip <= c & ax;
      self_test_active <= i[0];
      @(posedge mclk);
      xf(acmd(ax), 16, 1'b0, mk(ax, i[0] ? `ST_SELFTEST : `ST_ACCEL,
         enc(v, c)), 1'b1);
    end
    @(posedge mclk);
    self_test_active <= 1'b0;
    accel_x_clip <= 1'b0;
    accel_y_clip <= 1'b0;
    accel_x <= 12'sh064;
    temp_over <= 1'b1;
    repeat (4) @(posedge mclk);
    check("temp flag", {15'h0000, temp_fault_flag}, 16'h0001);
    xf(acmd(1'b0), 16, 1'b0, mk(1'b0, `ST_ERROR, 10'h020), 1'b1);
    pulse(0);
    check("temp flag", {15'h0000, temp_fault_flag}, 16'h0001);
    temp_over <= 1'b0;
    pulse(0);
    check("temp flag", {15'h0000, temp_fault_flag}, 16'h0000);
    xf(acmd(1'b0), 16, 1'b0, mk(1'b0, `ST_ACCEL, 10'h064), 1'b1);
    offset_monitor_enable <= 1'b1;
    offset_mon <= 10'sh034;
    repeat (4) @(posedge mclk);
    check("offset flag", {15'h0000, offset_fault_flag}, 16'h0001);
    xf(acmd(1'b0), 16, 1'b0, mk(1'b0, `ST_ERROR, 10'h020), 1'b1);
    offset_monitor_enable <= 1'b0;
    pulse(0);
    check("offset flag", {15'h0000, offset_fault_flag}, 16'h0000);
    xf(acmd(1'b0), 16, 1'b0, 16'h0000, 1'b0);
    xf(acmd(1'b1), 15, 1'b0, mk(1'b0, `ST_ERROR, 10'h001), 1'b1);
    check("class", 16'(cls), 16'(accel_err_pkg::CLS_EXTERNAL));
    xf(16'h8000, 17, 1'b0, mk(1'b0, `ST_ERROR, 10'h001), 1'b1);
    xf(16'h8000, 16, 1'b1, mk(1'b0, `ST_ERROR, 10'h001), 1'b1);
    xf(acmd(1'b0), 16, 1'b0, mk(1'b0, `ST_ACCEL, 10'h064), 1'b1);
    xf(acmd(1'b0), 16, 1'b0, 16'h0000, 1'b0);
    pulse(2);
    check("data error", {15'h0000, data_error_flag}, 16'h0001);
    temp_over <= 1'b1;
    xf(acmd(1'b1), 16, 1'b0, mk(1'b1, `ST_ERROR, 10'h200), 1'b1);
    xf(acmd(1'b1), 16, 1'b0, 16'h0000, 1'b0);
    xf(acmd(1'b1), 15, 1'b0, mk(1'b0, `ST_ERROR, 10'h201), 1'b1);
    check("class", 16'(cls), 16'(accel_err_pkg::CLS_CRITICAL));
    xf(acmd(1'b1), 16, 1'b0, 16'h0000, 1'b0);
    temp_over <= 1'b0;
    osc_fault <= 1'b1;
    repeat (4) @(posedge mclk);
    xf(acmd(1'b0), 16, 1'b0, 16'h0000, 1'b0);
    check("oscillator reply", rsp, 16'hFFFF);
    osc_fault <= 1'b0;
    pulse(1);
    check("controller reset", {13'h0000, reset_occurred_flag, init_busy,
          data_error_flag}, 16'h0006);
    wait_init();
    @(posedge mclk);
    undervoltage <= 1'b1;
    repeat (8) @(posedge mclk);
    undervoltage <= 1'b0;
    repeat (4) @(posedge mclk);
    check("undervoltage", {15'h0000, init_busy}, 16'h0001);
    end_sim();
  end
endmodule
`default_nettype wire
